// ### rtl/mmd_pkg.sv
/*
 Package for the memory map block decoder: address windows, block numbers,
 register offsets and state carriers. Assumes a 16-bit address bus.
*/
package mmd_pkg;
	localparam logic [15:0] MMD_IO_BASE     = 16'h1700;
	localparam logic [15:0] MMD_PAV_OFF     = 16'h1700;
	localparam logic [15:0] MMD_PADIR_OFF   = 16'h1701;
	localparam logic [15:0] MMD_PBV_OFF     = 16'h1702;
	localparam logic [15:0] MMD_PBDIR_OFF   = 16'h1703;
	localparam logic [15:0] MMD_TMR_LO      = 16'h1704;
	localparam logic [15:0] MMD_TMR_HI      = 16'h170F;
	localparam logic [15:0] MMD_URAM_LO     = 16'h1780;
	localparam logic [15:0] MMD_URAM_HI     = 16'h17BF;
	localparam logic [15:0] MMD_SRAM_LO     = 16'h17C0;
	localparam logic [15:0] MMD_SRAM_USR_HI = 16'h17EB;
	localparam logic [15:0] MMD_SRAM_HI     = 16'h17FF;
	localparam logic [15:0] MMD_VEC_NMI     = 16'h17FA;
	localparam logic [15:0] MMD_VEC_RST     = 16'h17FC;
	localparam logic [15:0] MMD_VEC_IRQ     = 16'h17FE;
	localparam logic [7:0]  MMD_PORT_RESET  = 8'h00;
	localparam int          MMD_BLK_LSB     = 10;
	localparam int          MMD_PAGE_LSB    = 8;
	localparam logic [2:0]  MMD_BLK_RAM     = 3'h0;
	localparam logic [2:0]  MMD_BLK_IO      = 3'h5;
	localparam logic [2:0]  MMD_BLK_ROM_B   = 3'h6;
	localparam logic [2:0]  MMD_BLK_ROM_A   = 3'h7;
	localparam logic [7:0]  MMD_STACK_PAGE  = 8'h01;

	typedef struct packed {
		logic [7:0] blk_sel;
		logic [4:0] page;
		logic       rom_a_cs;
		logic       rom_b_cs;
		logic       io_cs;
		logic       ram_cs;
		logic       stack_hit;
		logic       app_io_hit;
		logic       timer_cs;
		logic       vector_hit;
		logic       wr_ok;
		logic       drive_en;
	} mmd_dec_t;

	typedef struct packed {
		logic [7:0] port_a_val;
		logic [7:0] port_a_dir;
		logic [7:0] port_b_val;
		logic [7:0] port_b_dir;
	} mmd_ports_t;

	typedef struct packed {
		mmd_dec_t   dec;
		mmd_ports_t prt;
		logic [7:0] rd_data;
		logic       nmi_b;
		logic [1:0] stop_sync;
	} mmd_state_t;
endpackage

// ### rtl/mmd_decoder.sv
/*
 Memory map block decoder with the application port registers.
 Assumes the processor core drives address, data and write on mclk (the
 phase-two time base); the stop key arrives asynchronously, debounced.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Lowest 8192 addresses give eight exclusive selects.
// - Each block is four 256-location pages.
// - Select seven and six enable the two ROMs.
// - Select five covers chip RAM, I/O, timer.
// - Selects one to four enable no device.
// - Select zero enables on-board static RAM.
// - Page one of RAM is the stack.
// - Port registers sit at 1700 to 1703.
// - User timer window spans 1704 to 170F.
// - Vector cells at 17FA, 17FC, 17FE.
// - User RAM 1780-17BF and 17C0-17EB.
// - Stop key asserts the non-maskable interrupt.
// - Decoder makes selects for chips and RAM.
module mmd_decoder
	import mmd_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Processor bus
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        decoder_gate_input,
	output var  logic [7:0]  rdata,
	output var  logic        rdata_oe_b,
	// Selects
	output var  mmd_dec_t    dec,
	// Application port pins
	output var  mmd_ports_t  ports,
	// Stop key and interrupt
	input  wire logic        stop_key,
	output var  logic        nmi_b
);
	mmd_state_t st_r;
	mmd_state_t st_nxt;

	function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_win = (a >= lo) && (a <= hi);
	endfunction

	always_comb begin
		logic [2:0] blk;
		logic       live;
		blk = addr[MMD_BLK_LSB +: 3];
		live = decoder_gate_input && (addr[15:13] == 3'h0);
		st_nxt = st_r;
		st_nxt.dec.blk_sel = live ? (8'h01 << blk) : 8'h00;
		st_nxt.dec.page = addr[MMD_PAGE_LSB +: 5];
		st_nxt.dec.rom_a_cs = live && (blk == MMD_BLK_ROM_A);
		st_nxt.dec.rom_b_cs = live && (blk == MMD_BLK_ROM_B);
		st_nxt.dec.io_cs = live && (blk == MMD_BLK_IO);
		st_nxt.dec.ram_cs = live && (blk == MMD_BLK_RAM);
		st_nxt.dec.stack_hit = live && (blk == MMD_BLK_RAM)
			&& (addr[15:8] == MMD_STACK_PAGE);
		st_nxt.dec.app_io_hit = st_nxt.dec.io_cs && in_win(addr, MMD_PAV_OFF, MMD_PBDIR_OFF);
		st_nxt.dec.timer_cs = st_nxt.dec.io_cs && in_win(addr, MMD_TMR_LO, MMD_TMR_HI);
		st_nxt.dec.vector_hit = st_nxt.dec.io_cs && in_win(addr, MMD_VEC_NMI, MMD_SRAM_HI);
		// ROM and empty blocks never accept a write
		st_nxt.dec.wr_ok = wr && (st_nxt.dec.ram_cs || st_nxt.dec.io_cs);
		// Blocks one to four stay quiet so expansion memory can own the bus
		st_nxt.dec.drive_en = !wr && (st_nxt.dec.ram_cs || st_nxt.dec.io_cs
			|| st_nxt.dec.rom_a_cs || st_nxt.dec.rom_b_cs);
		st_nxt.rd_data = 8'h00;
		if (st_nxt.dec.app_io_hit) begin
			unique case (addr[1:0])
				2'h0: st_nxt.rd_data = st_r.prt.port_a_val;
				2'h1: st_nxt.rd_data = st_r.prt.port_a_dir;
				2'h2: st_nxt.rd_data = st_r.prt.port_b_val;
				2'h3: st_nxt.rd_data = st_r.prt.port_b_dir;
			endcase
		end
		if (st_nxt.dec.app_io_hit && st_nxt.dec.wr_ok) begin
			unique case (addr[1:0])
				2'h0: st_nxt.prt.port_a_val = wdata;
				2'h1: st_nxt.prt.port_a_dir = wdata;
				2'h2: st_nxt.prt.port_b_val = wdata;
				2'h3: st_nxt.prt.port_b_dir = wdata;
			endcase
		end
		st_nxt.stop_sync = {st_r.stop_sync[0], stop_key};
		st_nxt.nmi_b = !st_r.stop_sync[1];
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
			st_r.nmi_b <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dec = st_r.dec;
	assign ports = st_r.prt;
	assign rdata = st_r.rd_data;
	assign rdata_oe_b = !st_r.dec.drive_en;
	assign nmi_b = st_r.nmi_b;

	one_hot_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$onehot0(dec.blk_sel)) else $error("block selects not exclusive");
	gate_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(!decoder_gate_input || addr[15:13] != 3'h0) |=> dec.blk_sel == 8'h00)
		else $error("select active while decode disabled");
	rom_map_a: assert property (@(posedge mclk) disable iff (!rst_b)
		dec.rom_a_cs == dec.blk_sel[7] && dec.rom_b_cs == dec.blk_sel[6])
		else $error("rom select mismatch");
	io_map_a: assert property (@(posedge mclk) disable iff (!rst_b)
		dec.io_cs == dec.blk_sel[5]) else $error("io select mismatch");
	ram_map_a: assert property (@(posedge mclk) disable iff (!rst_b)
		dec.ram_cs == dec.blk_sel[0]) else $error("ram select mismatch");
	empty_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(|dec.blk_sel[4:1]) |-> rdata_oe_b && !dec.wr_ok)
		else $error("empty block driven");
	rom_nowrite_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(dec.rom_a_cs || dec.rom_b_cs) |-> !dec.wr_ok) else $error("rom accepted write");
	port_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(decoder_gate_input && wr && addr == MMD_PAV_OFF) |=> ports.port_a_val == $past(wdata))
		else $error("port a write lost");
	timer_win_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(decoder_gate_input && addr == MMD_TMR_HI) |=> dec.timer_cs)
		else $error("timer window wrong");
	vector_win_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(decoder_gate_input && addr == MMD_VEC_NMI) |=> dec.vector_hit)
		else $error("vector cell missed");
	stop_nmi_a: assert property (@(posedge mclk) disable iff (!rst_b)
		stop_key [*3] |=> !nmi_b) else $error("stop key did not raise nmi");
	// User RAM of both chips lies inside block five, so its select must follow
	user_ram_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(decoder_gate_input && addr >= MMD_URAM_LO && addr <= MMD_SRAM_USR_HI)
		|=> dec.io_cs && !dec.vector_hit) else $error("user ram not selected");

	rom_read_c: cover property (@(posedge mclk) dec.rom_a_cs && !rdata_oe_b);
	port_wr_c: cover property (@(posedge mclk) dec.app_io_hit && dec.wr_ok);
	stack_c: cover property (@(posedge mclk) dec.stack_hit);
	nmi_c: cover property (@(posedge mclk) $fell(nmi_b));
endmodule

`default_nettype wire

// ### sim/mmd_cpu_model.sv
/*
 Processor core model: drives address, data, write and decode gate.
 Assumes a free-running mclk; one access per task call.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_cpu_model (
	// Clock
	input  wire logic        mclk,
	// Processor bus
	output logic      [15:0] addr,
	output logic      [7:0]  wdata,
	output logic             wr,
	output logic             gate
);
	initial begin
		addr = 16'h0000;
		wdata = 8'h00;
		wr = 1'h0;
		gate = 1'h0;
	end

	// Writes go to user areas, a ROM block and an empty block, never 17EC-17FF nor 00EF-00FF; vector cells are only read
	task cyc(input logic [15:0] a, input logic w, input logic [7:0] d, input logic g);
		@(posedge mclk);
		addr <= a;
		wr <= w;
		// Released data bus shows the inverse, not a stale value
		wdata <= w ? d : ~wdata;
		gate <= g;
		@(posedge mclk);
		#1;
	endtask
endmodule
`default_nettype wire

// ### sim/mmd_decoder_tb.sv
/*
 Testbench for the memory map block decoder.
 Assumes mmd_pkg and the processor core model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_tb;
	import mmd_pkg::*;
	logic        mclk, rst_b, wr, gate, stop_key, rdata_oe_b, nmi_b;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata;
	mmd_dec_t    dec;
	mmd_ports_t  ports;
	int          fail_count = 0, compares = 0, cyc_n = 0;
	logic [15:0] ta [8] = '{16'h1703, 16'h1704, 16'h170F, 16'h1710,
		16'h17F9, 16'h17FA, 16'h17FC, 16'h17FE};

	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end

	mmd_cpu_model cpu_u (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .gate(gate));
	mmd_decoder dut_u (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
		.decoder_gate_input(gate), .rdata(rdata), .rdata_oe_b(rdata_oe_b), .dec(dec),
		.ports(ports), .stop_key(stop_key), .nmi_b(nmi_b));

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task results;
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Whole run needs about 80 cycles
	always @(posedge mclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 2000) begin
			fail_count++;
			results;
		end
	end

	initial begin
		rst_b = 1'h0;
		stop_key = 1'h0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'h1;
		chk("ports", ports, {4{MMD_PORT_RESET}});
		chk("nmi_b", nmi_b, 1);
		for (int b = 0; b < 8; b++) begin
			cpu_u.cyc({3'h0, b[2:0], 10'h100}, 1'h0, 8'h00, 1'h1);
			chk("blk_sel", dec.blk_sel, 8'h01 << b);
			chk("page", dec.page, {b[2:0], 2'h1});
			chk("rom", {dec.rom_a_cs, dec.rom_b_cs}, {b == 7, b == 6});
			chk("io_cs", dec.io_cs, b == 5);
			chk("ram", {dec.ram_cs, dec.stack_hit}, {2{b == 0}});
			chk("oe_b", rdata_oe_b, b inside {[1:4]});
		end
		cpu_u.cyc(16'h2000, 1'h0, 8'h00, 1'h1);
		chk("hi_bits", dec.blk_sel, 0);
		cpu_u.cyc(16'h1400, 1'h0, 8'h00, 1'h0);
		chk("gate", dec.blk_sel, 0);
		for (int i = 0; i < 4; i++) begin
			cpu_u.cyc(MMD_PAV_OFF + 16'(i), 1'h1, 8'hA0 + 8'(i), 1'h1);
			chk("app_io", {dec.app_io_hit, dec.wr_ok}, 2'h3);
		end
		chk("ports", ports, 32'hA0A1A2A3);
		for (int i = 0; i < 4; i++) begin
			cpu_u.cyc(MMD_PAV_OFF + 16'(i), 1'h0, 8'h00, 1'h1);
			chk("rdata", {rdata_oe_b, rdata}, 8'hA0 + i);
		end
		cpu_u.cyc(16'h1C00, 1'h1, 8'h5A, 1'h1);
		chk("rom_wr", dec.wr_ok, 0);
		cpu_u.cyc(16'h0C00, 1'h1, 8'h5A, 1'h1);
		chk("empty_wr", dec.wr_ok, 0);
		cpu_u.cyc(16'h0200, 1'h1, 8'h5A, 1'h1);
		chk("ram_wr", dec.wr_ok, 1);
		cpu_u.cyc(16'h17C0, 1'h1, 8'h5A, 1'h1);
		chk("user_ram", {dec.io_cs, dec.wr_ok, dec.vector_hit}, 3'h6);
		cpu_u.cyc(16'h17BF, 1'h0, 8'h00, 1'h1);
		chk("user_ram_rd", {dec.io_cs, rdata_oe_b}, 2'h2);
		for (int i = 0; i < 8; i++) begin
			cpu_u.cyc(ta[i], 1'h0, 8'h00, 1'h1);
			chk("timer", dec.timer_cs, i inside {1, 2});
			chk("vector", dec.vector_hit, i > 4);
		end
		@(posedge mclk);
		stop_key <= 1'h1;
		repeat (2) @(posedge mclk);
		#1 chk("nmi_b", nmi_b, 1);
		@(posedge mclk);
		#1 chk("nmi_b", nmi_b, 0);
		results;
	end
endmodule
`default_nettype wire
